// [logic/accel_sample_buffer_readout.sv]
// Function
// - Level counts stored bytes, six or three
// - Empty buffer reads level zero
// - Trigger flag in bit 7, rest zero
// - Flag shows trigger seen in trigger mode
// - Any flush write empties buffer, clears status unless a trigger event coincides in trigger mode
// - Drain reads ordered per resolution and mode
// - Further samples while host keeps clocking
// - No sample writes during drain read after the two-clock busy lag
// - Drained bytes are two's complement
// - Resolution bit picks width; enable activates
// - Modes FIFO stream trigger FILO, capacities
`timescale 1ns/1ps
`default_nettype none
`include "accel_buf_params.svh"

module accel_sample_buffer_readout #(
    parameter int DEPTH = `BUF_DEPTH
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire accel_buf_pkg::sample_store_control_s sample_store_control,
    input wire logic [6:0] sample_watermark_threshold,
    input wire logic sample_valid,
    input wire accel_buf_pkg::sample_s sample_data,
    input wire logic trigger_event,
    input wire logic bus_start,
    input wire logic bus_stop,
    input wire logic bus_wr_valid,
    input wire logic [7:0] bus_wr_data,
    input wire logic bus_rd_ack,
    output logic [7:0] bus_rd_data,
    output logic trigger_seen_flag,
    output logic [7:0] stored_byte_count
);
    // Byte-wide circular store in link domain read, sys domain written via
    // request handshake: the link side only asks, sys side owns all state.
    logic [7:0] mem_q [0:DEPTH-1];
    logic [7:0] wr_ptr_q;
    logic [7:0] rd_ptr_q;
    logic [7:0] level_q;
    logic trig_q;
    logic [6:0] pre_cnt_q;

    // Link-side: host bus decode on link_clk
    accel_buf_pkg::bus_state_e bus_state_q;
    logic [7:0] addr_q;
    logic draining_q;
    logic flush_tgl_q;
    logic pop_tgl_q;
    logic [7:0] link_rd_q;
    logic [7:0] level_shadow;
    logic trig_shadow;
    logic [7:0] head_shadow;
    logic [7:0] link_rd_d;

    // Reads answer from synchronised shadows, never from sys registers
    function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] lv,
                                            input logic tg, input logic [7:0] hd);
        case (a)
            `ADDR_BYTE_LEVEL: read_mux = lv;
            `ADDR_TRIG_STATUS: read_mux = {tg, 7'h00};
            `ADDR_DRAIN_PORT: read_mux = hd;
            default: read_mux = 8'h00;
        endcase
    endfunction : read_mux

    wire drain_sel = (addr_q == `ADDR_DRAIN_PORT);
    wire flush_sel = (addr_q == `ADDR_FLUSH);
    // First ack of a drain already takes a byte, so it pops as well
    wire pop_req = bus_rd_ack && drain_sel && (level_shadow != 8'h00);
    assign link_rd_d = read_mux(addr_q, level_shadow, trig_shadow, head_shadow);

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_state_q <= accel_buf_pkg::BUS_IDLE;
            addr_q <= 8'h00;
            draining_q <= 1'b0;
            flush_tgl_q <= 1'b0;
            pop_tgl_q <= 1'b0;
            link_rd_q <= 8'h00;
        end else begin
            case (bus_state_q)
                accel_buf_pkg::BUS_IDLE: begin
                    if (bus_start) begin
                        bus_state_q <= accel_buf_pkg::BUS_ADDR;
                    end
                end
                accel_buf_pkg::BUS_ADDR: begin
                    if (bus_wr_valid) begin
                        addr_q <= bus_wr_data;
                        bus_state_q <= accel_buf_pkg::BUS_WRITE;
                    end
                end
                accel_buf_pkg::BUS_WRITE: begin
                    if (bus_wr_valid && flush_sel) begin
                        flush_tgl_q <= ~flush_tgl_q;
                    end
                    draining_q <= drain_sel;
                    if (pop_req) begin
                        pop_tgl_q <= ~pop_tgl_q;
                    end
                    if (bus_rd_ack) begin
                        bus_state_q <= accel_buf_pkg::BUS_READ;
                    end
                end
                accel_buf_pkg::BUS_READ: begin
                    draining_q <= drain_sel;
                    if (pop_req) begin
                        pop_tgl_q <= ~pop_tgl_q;
                    end
                end
                default: bus_state_q <= accel_buf_pkg::BUS_IDLE;
            endcase
            if (bus_stop) begin
                bus_state_q <= accel_buf_pkg::BUS_IDLE;
                draining_q <= 1'b0;
            end
            link_rd_q <= link_rd_d;
        end
    end

    // Sys-side status to link domain; values change slowly vs. byte time
    level_sync #(.WIDTH(17)) u_status_sync (
        .clk(link_clk),
        .rst(sys_rst),
        .async_in({level_q, trig_q, mem_q[rd_ptr_q]}),
        .sync_out({level_shadow, trig_shadow, head_shadow})
    );

    logic flush_p;
    logic pop_p;
    logic drain_busy;

    toggle_sync u_flush_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .toggle_in(flush_tgl_q),
        .pulse_out(flush_p)
    );

    toggle_sync u_pop_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .toggle_in(pop_tgl_q),
        .pulse_out(pop_p)
    );

    // Busy lags two sample clocks; a sample inside that gap is still kept
    level_sync #(.WIDTH(1)) u_busy_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .async_in(draining_q),
        .sync_out(drain_busy)
    );

    // Sys-side storage control
    wire hi_res = sample_store_control.sample_resolution_select;
    wire [1:0] mode = sample_store_control.mode;
    wire [7:0] set_bytes = hi_res ? `BYTES_HI_RES : `BYTES_LO_RES;
    wire [7:0] cap = hi_res ? `CAP_HI_RES : `CAP_LO_RES;
    // Nine bits so a resolution change on a nearly full store cannot wrap
    wire full = ({1'b0, level_q} + {1'b0, set_bytes}) > {1'b0, cap};
    wire discard_old = (mode == `MODE_STREAM) || (mode == `MODE_FILO);
    wire trig_mode = (mode == `MODE_TRIGGER);
    wire pre_full = pre_cnt_q >= sample_watermark_threshold;
    wire accept = sample_valid && sample_store_control.sample_store_enable
        && !drain_busy && (!full || discard_old);
    wire drop_old = accept && full;
    wire filo = (mode == `MODE_FILO);

    function automatic logic [7:0] wrap_add(input logic [7:0] p, input logic [7:0] n);
        logic [8:0] s;
        s = {1'b0, p} + {1'b0, n};
        wrap_add = (s >= 9'(DEPTH)) ? 8'(s - 9'(DEPTH)) : s[7:0];
    endfunction : wrap_add

    function automatic logic [7:0] wrap_sub1(input logic [7:0] p);
        wrap_sub1 = (p == 8'h00) ? 8'(DEPTH - 1) : p - 8'h01;
    endfunction : wrap_sub1

    // Bytes per set: low res keeps upper 8 bits, high res low nibble byte (bits 3:0 in 7:4) then upper 8 bits
    function automatic logic [7:0] pick_byte(input accel_buf_pkg::sample_s s,
                                             input logic hr, input logic [2:0] i);
        logic [11:0] v;
        v = (i[2:1] == 2'd0) ? s.x : (i[2:1] == 2'd1) ? s.y : s.z;
        if (!hr) begin
            v = (i == 3'd0) ? s.x : (i == 3'd1) ? s.y : s.z;
            pick_byte = v[11:4];
        end else if (!i[0]) begin
            pick_byte = {v[3:0], 4'h0};
        end else begin
            pick_byte = v[11:4];
        end
    endfunction : pick_byte

    // FILO: samples written in reverse byte order and read backward so the
    // newest sample leaves first with its bytes in normal order.
    wire [7:0] pop_ptr = filo ? wrap_sub1(rd_ptr_q) : wrap_add(rd_ptr_q, 8'h01);

    always_ff @(posedge sys_clk) begin
        if (accept) begin
            for (int i = 0; i < 6; i++) begin
                if (i < int'(set_bytes)) begin
                    mem_q[wrap_add(wr_ptr_q, 8'(i))] <= pick_byte(sample_data, hi_res,
                        filo ? 3'(int'(set_bytes) - 1 - i) : 3'(i));
                end
            end
        end
    end

    logic [7:0] wr_ptr_d;
    logic [7:0] rd_ptr_d;
    logic [7:0] level_d;

    always_comb begin
        wr_ptr_d = accept ? wrap_add(wr_ptr_q, set_bytes) : wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        level_d = level_q;
        if (filo) begin
            if (accept) begin
                rd_ptr_d = wrap_sub1(wrap_add(wr_ptr_q, set_bytes));
            end else if (pop_p && level_q != 8'h00) begin
                rd_ptr_d = pop_ptr;
            end
        end else if (drop_old) begin
            rd_ptr_d = wrap_add(rd_ptr_q, set_bytes);
        end else if (pop_p && level_q != 8'h00) begin
            rd_ptr_d = pop_ptr;
        end
        if (accept && !drop_old) begin
            level_d = level_q + set_bytes;
        end else if (!accept && pop_p && level_q != 8'h00) begin
            level_d = level_q - 8'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_q <= 8'h00;
            rd_ptr_q <= 8'h00;
            level_q <= `LEVEL_RESET;
            trig_q <= 1'b0;
            pre_cnt_q <= 7'h00;
        end else if (flush_p) begin
            wr_ptr_q <= 8'h00;
            rd_ptr_q <= 8'h00;
            level_q <= `LEVEL_RESET;
            // An event in the flush cycle survives the clear
            trig_q <= trig_mode && trigger_event;
            pre_cnt_q <= 7'h00;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            level_q <= level_d;
            // Trigger mode keeps only threshold samples before the event
            if (trig_mode && trigger_event) begin
                trig_q <= 1'b1;
            end
            if (trig_mode && !trig_q && accept && pre_full) begin
                rd_ptr_q <= wrap_add(rd_ptr_q, set_bytes);
                level_q <= level_q;
            end else if (accept && pre_cnt_q != 7'h7F) begin
                pre_cnt_q <= pre_cnt_q + 7'h01;
            end
        end
    end

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rd_data <= 8'h00;
        end else begin
            bus_rd_data <= link_rd_q;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trigger_seen_flag <= 1'b0;
            stored_byte_count <= 8'h00;
        end else begin
            trigger_seen_flag <= trig_q;
            stored_byte_count <= level_q;
        end
    end
endmodule : accel_sample_buffer_readout

`default_nettype wire

// [include/accel_buf_params.svh]
`ifndef ACCEL_BUF_PARAMS_SVH
`define ACCEL_BUF_PARAMS_SVH

`define ADDR_BYTE_LEVEL 8'h34
`define ADDR_TRIG_STATUS 8'h35
`define ADDR_FLUSH 8'h36
`define ADDR_DRAIN_PORT 8'h7F
`define TRIG_FLAG_BIT 7
`define BYTES_HI_RES 8'h06
`define BYTES_LO_RES 8'h03
`define CAP_HI_RES 8'd246
`define CAP_LO_RES 8'd252
`define BUF_DEPTH 256
`define MODE_FIFO 2'h0
`define MODE_STREAM 2'h1
`define MODE_TRIGGER 2'h2
`define MODE_FILO 2'h3
`define LEVEL_RESET 8'h00

`endif

// [include/accel_buf_pkg.sv]
package accel_buf_pkg;

    typedef enum logic [1:0] {
        MODE_FIFO_E = 2'b00,
        MODE_STREAM_E = 2'b01,
        MODE_TRIGGER_E = 2'b10,
        MODE_FILO_E = 2'b11
    } buf_mode_e;

    typedef struct packed {
        logic sample_store_enable;
        logic sample_resolution_select;
        logic [1:0] mode;
    } sample_store_control_s;

    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } sample_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ADDR = 2'b01,
        BUS_WRITE = 2'b10,
        BUS_READ = 2'b11
    } bus_state_e;

endpackage : accel_buf_pkg

// [logic/level_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : level_sync

`default_nettype wire

// [logic/toggle_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module toggle_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic toggle_in,
    output logic pulse_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Event crosses as a toggle; edge seen only after two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            meta_q <= toggle_in;
            sync_q <= meta_q;
            last_q <= sync_q;
            pulse_out <= sync_q ^ last_q;
        end
    end
endmodule : toggle_sync

`default_nettype wire

// [tb/accel_buf_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module accel_buf_asserts (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire accel_buf_pkg::sample_store_control_s sample_store_control,
    input wire logic sample_valid,
    input wire logic trigger_event,
    input wire logic bus_start,
    input wire logic bus_stop,
    input wire logic bus_wr_valid,
    input wire logic [7:0] bus_wr_data,
    input wire logic trigger_seen_flag,
    input wire logic [7:0] stored_byte_count
);
    logic exp_q;
    logic drain_q;
    logic [7:0] sel_q;
    wire logic [7:0] lv = stored_byte_count;
    wire logic hr = sample_store_control.sample_resolution_select;
    wire logic flush_hit = bus_wr_valid && !exp_q && sel_q == 8'h36;
    // Tracks the address byte of each frame and an open drain read
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exp_q <= 1'b0;
            sel_q <= 8'h00;
            drain_q <= 1'b0;
        end else if (bus_start) begin
            exp_q <= 1'b1;
        end else if (bus_stop) begin
            drain_q <= 1'b0;
        end else if (bus_wr_valid && exp_q) begin
            exp_q <= 1'b0;
            sel_q <= bus_wr_data;
            drain_q <= bus_wr_data == 8'h7F;
        end
    end
    level_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        lv > $past(lv) |-> lv - $past(lv) == (hr ? 8'h06 : 8'h03)) else $error("bad step");
    level_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        lv > $past(lv) |-> $past(sample_valid) || $past(sample_valid, 2)
        || $past(sample_valid, 3)) else $error("rise without sample");
    level_cap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        lv <= (hr ? 8'hF6 : 8'hFC)) else $error("level above capacity");
    level_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        lv < $past(lv) |-> lv == $past(lv) - 8'h01 || lv == 8'h00) else $error("bad fall");
    flag_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(trigger_seen_flag) |-> sample_store_control.mode == accel_buf_pkg::MODE_TRIGGER_E)
        else $error("flag outside trigger mode");
    flag_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(trigger_seen_flag) |-> $past(trigger_event) || $past(trigger_event, 2)
        || $past(trigger_event, 3)) else $error("flag without event");
    store_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !sample_store_control.sample_store_enable |=> !(lv > $past(lv))) else $error("stored off");
    drain_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        drain_q [*4] |=> !(lv > $past(lv))) else $error("stored during drain");
    flush_clear_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        flush_hit |-> ##[1:200] (lv == 8'h00 && !trigger_seen_flag)) else $error("flush missed");
    reset_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> lv == 8'h00 && !trigger_seen_flag) else $error("reset not zero");
    cover property (@(posedge sys_clk) lv == 8'hF6);
    cover property (@(posedge sys_clk) $rose(trigger_seen_flag));
    cover property (@(posedge sys_clk) drain_q && sample_valid);
endmodule : accel_buf_asserts
bind accel_sample_buffer_readout accel_buf_asserts chk (.sys_clk, .sys_rst, .link_clk,
    .sample_store_control, .sample_valid, .trigger_event, .bus_start, .bus_stop,
    .bus_wr_valid, .bus_wr_data, .trigger_seen_flag, .stored_byte_count);
`default_nettype wire

// [tb/i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input wire logic link_clk,
    input wire logic [7:0] bus_rd_data,
    output logic bus_start,
    output logic bus_stop,
    output logic bus_wr_valid,
    output logic [7:0] bus_wr_data,
    output logic bus_rd_ack
);
    initial {bus_start, bus_stop, bus_wr_valid, bus_rd_ack, bus_wr_data} = '0;
    // Idle data lines show the inverse so stale bytes are never mistaken
    task automatic put(input logic [7:0] b);
        bus_wr_valid <= 1'b1;
        bus_wr_data <= b;
        @(posedge link_clk);
        bus_wr_valid <= 1'b0;
        bus_wr_data <= ~b;
        @(posedge link_clk);
    endtask : put
    task automatic frame_on(input logic [7:0] a);
        @(posedge link_clk);
        bus_start <= 1'b1;
        @(posedge link_clk);
        bus_start <= 1'b0;
        put(a);
    endtask : frame_on
    task automatic frame_off();
        bus_stop <= 1'b1;
        @(posedge link_clk);
        bus_stop <= 1'b0;
        @(posedge link_clk);
    endtask : frame_off
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        frame_on(a);
        put(d);
        frame_off();
    endtask : wr
    // Acks are spaced wide so each pop crosses into the sample clock
    task automatic rd(input logic [7:0] a, input int n, output logic [47:0] q);
        q = '0;
        frame_on(a);
        repeat (4) @(posedge link_clk);
        for (int i = 0; i < n; i++) begin
            q = {q[39:0], bus_rd_data};
            bus_rd_ack <= 1'b1;
            @(posedge link_clk);
            bus_rd_ack <= 1'b0;
            repeat (90) @(posedge link_clk);
        end
        frame_off();
    endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// [tb/accel_sample_buffer_readout_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module accel_sample_buffer_readout_bench;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic valid = 1'b0;
    logic trig = 1'b0;
    accel_buf_pkg::sample_store_control_s ctl = '0;
    accel_buf_pkg::sample_s smp = '0;
    logic start, stop, wv, ack, flag;
    logic [7:0] wd, rd, lvl;
    logic [47:0] q;
    int n_fail = 0;
    int n_tests = 0;
    // Rows: resolution, sample count, expected level
    logic [23:0] rows [4] = '{24'h01020C, 24'h000309, 24'h010000, 24'h000103};
    always #50 sys_clk = ~sys_clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    accel_sample_buffer_readout DUT (.sys_clk, .sys_rst, .link_clk,
        .sample_store_control(ctl), .sample_watermark_threshold(7'h00),
        .sample_valid(valid), .sample_data(smp), .trigger_event(trig), .bus_start(start),
        .bus_stop(stop), .bus_wr_valid(wv), .bus_wr_data(wd), .bus_rd_ack(ack),
        .bus_rd_data(rd), .trigger_seen_flag(flag), .stored_byte_count(lvl));
    i2c_host_model host (.link_clk, .bus_rd_data(rd), .bus_start(start), .bus_stop(stop),
        .bus_wr_valid(wv), .bus_wr_data(wd), .bus_rd_ack(ack));
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : ticks
    task automatic push(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(posedge sys_clk);
        smp <= {x, y, z};
        valid <= 1'b1;
        @(posedge sys_clk);
        valid <= 1'b0;
    endtask : push
    task automatic setup(input accel_buf_pkg::buf_mode_e m, input logic r);
        @(posedge sys_clk);
        ctl <= {1'b1, r, m};
        host.wr(8'h36, 8'hA5);
        ticks(10);
    endtask : setup
    // Third sample lands mid-read and must be refused
    task automatic drain(input accel_buf_pkg::buf_mode_e m, input logic [23:0] exp);
        setup(m, 1'b0);
        push(12'h8A5, 12'h123, 12'hFF0);
        push(12'h7F0, 12'h801, 12'h05A);
        ticks(10);
        fork
            host.rd(8'h7F, 3, q);
            begin
                ticks(4);
                push(12'h111, 12'h222, 12'h333);
            end
        join
        ticks(10);
        check(q[23:0], exp);
        check(lvl, 24'h3);
    endtask : drain
    initial begin
        #1000000;
        n_fail++;
        close_out();
    end
    initial begin
        ticks(12);
        sys_rst <= 1'b0;
        ticks(3);
        check({lvl, 7'h00, flag}, 24'h0);
        foreach (rows[i]) begin
            setup(accel_buf_pkg::MODE_FIFO_E, rows[i][16]);
            repeat (rows[i][15:8]) push(12'h123, 12'h456, 12'h789);
            ticks(10);
            check(lvl, rows[i][7:0]);
            host.rd(8'h34, 1, q);
            check(q[7:0], rows[i][7:0]);
            host.rd(8'h35, 1, q);
            check(q[7:0], 24'h0);
        end
        setup(accel_buf_pkg::MODE_FIFO_E, 1'b1);
        repeat (42) push(12'h001, 12'h002, 12'h003);
        ticks(10);
        check(lvl, 24'hF6);
        setup(accel_buf_pkg::MODE_STREAM_E, 1'b0);
        repeat (85) push(12'h001, 12'h002, 12'h003);
        ticks(10);
        check(lvl, 24'hFC);
        drain(accel_buf_pkg::MODE_FIFO_E, 24'h8A12FF);
        drain(accel_buf_pkg::MODE_FILO_E, 24'h7F8005);
        host.wr(8'h36, 8'h5A);
        ticks(10);
        check(lvl, 24'h0);
        setup(accel_buf_pkg::MODE_TRIGGER_E, 1'b0);
        push(12'h010, 12'h020, 12'h030);
        check(flag, 24'h0);
        @(posedge sys_clk);
        trig <= 1'b1;
        @(posedge sys_clk);
        trig <= 1'b0;
        ticks(10);
        check(flag, 24'h1);
        host.rd(8'h35, 1, q);
        check(q[7:0], 24'h80);
        host.rd(8'h7F, 3, q);
        host.wr(8'h36, 8'h00);
        ticks(10);
        check({lvl, 7'h00, flag}, 24'h0);
        close_out();
    end
endmodule : accel_sample_buffer_readout_bench
`default_nettype wire
